// *** logic/dbt_pkg.sv ***
// Shared constants and types of the debug bus trigger block.
`default_nettype none
package dbt_pkg;
  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] CMP_FIRST_OFS  = 8'h00;
  localparam logic [7:0] CMP_SECOND_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS       = 8'h08;
  localparam logic [7:0] STATUS_OFS     = 8'h0C;
  localparam logic [7:0] TRACE_OFS      = 8'h10;

  // Control register bit positions.
  localparam int CTRL_ENABLE_BIT   = 0;
  localparam int CTRL_ARM_BIT      = 1;
  localparam int CTRL_TAG_BIT      = 2;
  localparam int CTRL_BREAK_EN_BIT = 3;
  localparam int CTRL_RWCHK_BIT    = 4;
  localparam int CTRL_RWVAL_BIT    = 5;
  localparam int CTRL_BEGIN_BIT    = 6;
  localparam int CTRL_MODE_LSB     = 8;
  localparam int CTRL_MODE_W       = 4;

  // Status register bit positions.
  localparam int STAT_FIRST_BIT    = 7;
  localparam int STAT_SECOND_BIT   = 6;
  localparam int STAT_RUN_BIT      = 5;
  localparam int STAT_COUNT_LSB    = 0;
  localparam int COUNT_W           = 4;

  // Reset values and the valid count limit.
  localparam logic [15:0] CMP_RESET   = 16'h0000;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [3:0]  COUNT_MAX   = 4'h8;

  // AHB-Lite transfer types and response.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [3:0] {
    MODE_A_ONLY      = 4'h0,
    MODE_A_OR_B      = 4'h1,
    MODE_A_THEN_B    = 4'h2,
    MODE_A_AND_DATA  = 4'h3,
    MODE_A_NOT_DATA  = 4'h4,
    MODE_STORE_B     = 4'h5,
    MODE_A_THEN_STORE= 4'h6,
    MODE_INSIDE      = 4'h7,
    MODE_OUTSIDE     = 4'h8
  } dbt_mode_t;
endpackage
`default_nettype wire

// *** logic/dbt_fifo_if.sv ***
// Handshake bundle between the trigger logic and its trace FIFO.
`timescale 1ns/10ps
`default_nettype none
interface dbt_fifo_if #(parameter int WIDTH = 24);
  logic             clear;
  logic             inValid;
  logic             inReady;
  logic [WIDTH-1:0] inData;
  logic             outValid;
  logic             outReady;
  logic [WIDTH-1:0] outData;
  modport buffer (input clear, input inValid, input inData, input outReady,
                  output inReady, output outValid, output outData);
  modport user   (output clear, output inValid, output inData, output outReady,
                  input inReady, input outValid, input outData);
endinterface
`default_nettype wire

// *** logic/dbt_fifo.sv ***
// Trace FIFO with width and depth parameters and valid/ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module dbt_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input  wire logic   mclk,
  input  wire logic   rst,
  dbt_fifo_if.buffer  fifo
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wrPtr_reg;
  logic [PW-1:0]    rdPtr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             pop;

  assign fifo.inReady  = (count_reg != CW'(DEPTH));
  assign fifo.outValid = (count_reg != '0);
  assign fifo.outData  = mem_reg[rdPtr_reg];
  assign push = fifo.inValid && fifo.inReady;
  assign pop  = fifo.outValid && fifo.outReady;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_reg[wrPtr_reg] <= fifo.inData;
    end
  end

  // Pointers wrap by compare so that depths other than powers of two work.
  always_ff @(posedge mclk) begin
    if (rst || fifo.clear) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end
endmodule // dbt_fifo
`default_nettype wire

// *** logic/dbt_match.sv ***
// Address, data and direction comparators against the two comparator values.
`timescale 1ns/10ps
`default_nettype none
module dbt_match #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input  wire logic [ADDR_W-1:0] busAddr,
  input  wire logic [DATA_W-1:0] busData,
  input  wire logic              busRead,
  input  wire logic [ADDR_W-1:0] cmpFirst,
  input  wire logic [ADDR_W-1:0] cmpSecond,
  input  wire logic              rwCheck,
  input  wire logic              rwValue,
  output logic                   firstAddrEq,
  output logic                   secondAddrEq,
  output logic                   dataEq,
  output logic                   rwOk,
  output logic                   atOrAboveFirst,
  output logic                   atOrBelowSecond
);
  assign firstAddrEq     = (busAddr == cmpFirst);
  assign secondAddrEq    = (busAddr == cmpSecond);
  // Only the low half of the second comparator takes part in data compares.
  assign dataEq          = (busData == cmpSecond[DATA_W-1:0]);
  assign rwOk            = !rwCheck || (busRead == rwValue);
  assign atOrAboveFirst  = (busAddr >= cmpFirst);
  assign atOrBelowSecond = (busAddr <= cmpSecond);
endmodule // dbt_match
`default_nettype wire

// *** logic/dbt_top.sv ***
// Debug bus trigger block: comparators, trigger modes, trace capture, AHB-Lite registers.
// Function
// (RULE1) First-only mode triggers on first address match.
// (RULE2) Either mode triggers on any address match.
// (RULE3) Second match triggers only after earlier first.
// (RULE4) Full mode: address, low data byte, direction.
// (RULE5) Not-data mode: address, data unequal, direction.
// (RULE6) Tag breakpoint in full mode ignores data.
// (RULE7) Store mode captures on second match; full ends.
// (RULE8) After first match, second matches capture data.
// (RULE9) Inside range triggers with both bounds inclusive.
// (RULE10) Outside range triggers strictly below or above.
// (RULE11) Arm while enabled; run ends, flag drops.
// (RULE12) Hit flags clear at start, set while armed.
// (RULE13) Valid count clears at start, never decrements.
// (RULE14) Matches evaluated only while armed, once per cycle.
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module dbt_top #(
  parameter int ADDR_W     = 16,
  parameter int DATA_W     = 8,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              busValid,
  input  wire logic [ADDR_W-1:0] busAddr,
  input  wire logic [DATA_W-1:0] busData,
  input  wire logic              busRead,
  output logic                   breakReq
);
  localparam int WORD_W = ADDR_W + DATA_W;

  logic [ADDR_W-1:0] cmpFirst_reg;
  logic [ADDR_W-1:0] cmpSecond_reg;
  logic [31:0]       ctrl_reg;
  logic              runActive_reg;
  logic              seqSeen_reg;
  logic              traceOn_reg;
  logic              firstHit_reg;
  logic              secondHit_reg;
  logic [3:0]        validWords_reg;
  logic              wrPend_reg;
  logic [7:0]        wrAddr_reg;
  logic [31:0]       hrdata_reg;
  logic              hreadyout_reg;
  logic              hresp_reg;
  logic              breakReq_reg;

  dbt_pkg::dbt_mode_t mode;
  logic              enable;
  logic              tagMode;
  logic              brkEnable;
  logic              beginTrace;
  logic              addrPhase;
  logic              ctrlWrite;
  logic              runStart;
  logic              runStop;
  logic              cycleLive;
  logic              firstAddrEq;
  logic              secondAddrEq;
  logic              dataEq;
  logic              rwOk;
  logic              atOrAboveFirst;
  logic              atOrBelowSecond;
  logic              trigger;
  logic              firstCond;
  logic              secondCond;
  logic              storeMode;
  logic              fullMode;
  logic              captureWant;
  logic              capture;
  logic              breakHit;

  dbt_fifo_if #(.WIDTH(WORD_W)) traceIf ();

  dbt_match #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_match (
    .busAddr         (busAddr),
    .busData         (busData),
    .busRead         (busRead),
    .cmpFirst        (cmpFirst_reg),
    .cmpSecond       (cmpSecond_reg),
    .rwCheck         (ctrl_reg[dbt_pkg::CTRL_RWCHK_BIT]),
    .rwValue         (ctrl_reg[dbt_pkg::CTRL_RWVAL_BIT]),
    .firstAddrEq     (firstAddrEq),
    .secondAddrEq    (secondAddrEq),
    .dataEq          (dataEq),
    .rwOk            (rwOk),
    .atOrAboveFirst  (atOrAboveFirst),
    .atOrBelowSecond (atOrBelowSecond)
  );

  dbt_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk (mclk),
    .rst  (rst),
    .fifo (traceIf.buffer)
  );

  assign mode       = dbt_pkg::dbt_mode_t'(ctrl_reg[dbt_pkg::CTRL_MODE_LSB +: dbt_pkg::CTRL_MODE_W]);
  assign enable     = ctrl_reg[dbt_pkg::CTRL_ENABLE_BIT];
  assign tagMode    = ctrl_reg[dbt_pkg::CTRL_TAG_BIT];
  assign brkEnable  = ctrl_reg[dbt_pkg::CTRL_BREAK_EN_BIT];
  assign beginTrace = ctrl_reg[dbt_pkg::CTRL_BEGIN_BIT];
  assign storeMode  = (mode == dbt_pkg::MODE_STORE_B) || (mode == dbt_pkg::MODE_A_THEN_STORE);
  assign fullMode   = (mode == dbt_pkg::MODE_A_AND_DATA) || (mode == dbt_pkg::MODE_A_NOT_DATA);

  // AHB-Lite: zero wait states, so every NONSEQ address phase with hsel and hready is taken.
  assign addrPhase = hsel && hready && (htrans == dbt_pkg::HTRANS_NONSEQ);
  assign ctrlWrite = wrPend_reg && (wrAddr_reg == dbt_pkg::CTRL_OFS);
  assign runStart  = ctrlWrite && !runActive_reg
                     && hwdata[dbt_pkg::CTRL_ARM_BIT] && hwdata[dbt_pkg::CTRL_ENABLE_BIT];

  // Bus cycles count only while a run is active.
  assign cycleLive = busValid && runActive_reg; // see RULE14

  always_comb begin
    trigger    = 1'b0;
    firstCond  = firstAddrEq;
    secondCond = secondAddrEq;
    case (mode)
      dbt_pkg::MODE_A_ONLY: begin
        trigger = firstAddrEq; // see RULE1
      end
      dbt_pkg::MODE_A_OR_B: begin
        trigger = firstAddrEq || secondAddrEq; // see RULE2
      end
      dbt_pkg::MODE_A_THEN_B: begin
        trigger = seqSeen_reg && secondAddrEq; // see RULE3
      end
      dbt_pkg::MODE_A_AND_DATA: begin
        secondCond = dataEq;
        trigger    = firstAddrEq && dataEq && rwOk; // see RULE4
      end
      dbt_pkg::MODE_A_NOT_DATA: begin
        secondCond = !dataEq;
        trigger    = firstAddrEq && !dataEq && rwOk; // see RULE5
      end
      dbt_pkg::MODE_STORE_B: begin
        trigger = secondAddrEq; // see RULE7
      end
      dbt_pkg::MODE_A_THEN_STORE: begin
        trigger = seqSeen_reg && secondAddrEq; // see RULE8
      end
      dbt_pkg::MODE_INSIDE: begin
        firstCond  = atOrAboveFirst;
        secondCond = atOrBelowSecond;
        trigger    = atOrAboveFirst && atOrBelowSecond; // see RULE9
      end
      dbt_pkg::MODE_OUTSIDE: begin
        firstCond  = !atOrAboveFirst;
        secondCond = !atOrBelowSecond;
        trigger    = !atOrAboveFirst || !atOrBelowSecond; // see RULE10
      end
      default: begin
        trigger = 1'b0;
      end
    endcase
    trigger    = trigger && cycleLive;
    firstCond  = firstCond && cycleLive;
    secondCond = secondCond && cycleLive;
  end

  // Store modes capture on each event; begin trace captures every cycle from the
  // trigger on; end trace captures from arming and keeps the oldest words once full.
  always_comb begin
    if (storeMode) begin
      captureWant = trigger; // see RULE7, RULE8
    end else if (beginTrace) begin
      captureWant = cycleLive && (traceOn_reg || trigger);
    end else begin
      captureWant = cycleLive;
    end
  end
  assign capture = captureWant && traceIf.inReady;

  assign traceIf.clear    = runStart;
  assign traceIf.inValid  = captureWant;
  assign traceIf.inData   = {busAddr, busData};
  assign traceIf.outReady = addrPhase && !hwrite && (haddr[7:0] == dbt_pkg::TRACE_OFS);

  // A full trace buffer ends begin-trace and store runs; a trigger ends end-trace runs.
  always_comb begin
    runStop = 1'b0;
    if (runActive_reg) begin
      if (ctrlWrite && (!hwdata[dbt_pkg::CTRL_ARM_BIT] || !hwdata[dbt_pkg::CTRL_ENABLE_BIT])) begin
        runStop = 1'b1; // see RULE11
      end else if ((storeMode || beginTrace) && !traceIf.inReady) begin
        runStop = 1'b1; // see RULE7, RULE8, RULE11
      end else if (!storeMode && !beginTrace && trigger) begin
        runStop = 1'b1; // see RULE11
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      runActive_reg <= 1'b0;
    end else if (runStart) begin
      runActive_reg <= 1'b1; // see RULE11
    end else if (runStop) begin
      runActive_reg <= 1'b0; // see RULE11
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || runStart) begin
      seqSeen_reg <= 1'b0;
      traceOn_reg <= 1'b0;
    end else begin
      if (firstAddrEq && cycleLive) begin
        seqSeen_reg <= 1'b1; // see RULE3, RULE8
      end
      if (trigger) begin
        traceOn_reg <= 1'b1;
      end
    end
  end

  // Hit flags: a set in the same cycle would win over the clear, though a run start
  // never overlaps a live cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      firstHit_reg  <= 1'b0;
      secondHit_reg <= 1'b0;
    end else begin
      firstHit_reg  <= firstCond || (firstHit_reg && !runStart); // see RULE12
      secondHit_reg <= secondCond || (secondHit_reg && !runStart); // see RULE12
    end
  end

  // The count is a record of the run; reading the buffer does not lower it.
  always_ff @(posedge mclk) begin
    if (rst || runStart) begin
      validWords_reg <= '0; // see RULE13
    end else if (capture && (validWords_reg != dbt_pkg::COUNT_MAX)) begin
      validWords_reg <= validWords_reg + 4'h1; // see RULE13
    end
  end

  // In full modes a tag request ignores the data compare.
  assign breakHit = (tagMode && fullMode) ? (firstAddrEq && cycleLive) : trigger; // see RULE6

  always_ff @(posedge mclk) begin
    if (rst) begin
      breakReq_reg <= 1'b0;
    end else begin
      breakReq_reg <= brkEnable && breakHit;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
    end else begin
      wrPend_reg <= addrPhase && hwrite;
      wrAddr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmpFirst_reg  <= dbt_pkg::CMP_RESET;
      cmpSecond_reg <= dbt_pkg::CMP_RESET;
      ctrl_reg      <= dbt_pkg::CTRL_RESET;
    end else if (wrPend_reg) begin
      case (wrAddr_reg)
        dbt_pkg::CMP_FIRST_OFS: begin
          cmpFirst_reg <= hwdata[ADDR_W-1:0];
        end
        dbt_pkg::CMP_SECOND_OFS: begin
          cmpSecond_reg <= hwdata[ADDR_W-1:0];
        end
        dbt_pkg::CTRL_OFS: begin
          ctrl_reg <= hwdata & 32'h0000_0F7F;
        end
        default: begin
          ctrl_reg <= ctrl_reg;
        end
      endcase
    end
  end

  // Read data is latched at the address phase so it stands through the data phase.
  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b0;
      hresp_reg     <= dbt_pkg::HRESP_OKAY;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= dbt_pkg::HRESP_OKAY;
      if (addrPhase && !hwrite) begin
        case (haddr[7:0])
          dbt_pkg::CMP_FIRST_OFS:  hrdata_reg <= 32'(cmpFirst_reg);
          dbt_pkg::CMP_SECOND_OFS: hrdata_reg <= 32'(cmpSecond_reg);
          dbt_pkg::CTRL_OFS: begin
            hrdata_reg <= ctrl_reg;
            hrdata_reg[dbt_pkg::CTRL_ARM_BIT] <= runActive_reg;
          end
          dbt_pkg::STATUS_OFS: begin
            hrdata_reg <= {24'h00_0000, firstHit_reg, secondHit_reg, runActive_reg,
                           1'b0, validWords_reg};
          end
          dbt_pkg::TRACE_OFS: begin
            hrdata_reg <= traceIf.outValid ? 32'(traceIf.outData) : 32'h0000_0000;
          end
          default: hrdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;
  assign breakReq  = breakReq_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_first_only: assert property ( // see RULE1
    runActive_reg && busValid && mode == dbt_pkg::MODE_A_ONLY && busAddr == cmpFirst_reg
    |-> trigger) else $error("first-only match did not trigger");
  a_either_cmp: assert property ( // see RULE2
    runActive_reg && busValid && mode == dbt_pkg::MODE_A_OR_B
    && (busAddr == cmpFirst_reg || busAddr == cmpSecond_reg) |-> trigger)
    else $error("either-comparator match did not trigger");
  a_seq_order: assert property ( // see RULE3
    trigger && mode == dbt_pkg::MODE_A_THEN_B |-> seqSeen_reg && busAddr == cmpSecond_reg)
    else $error("sequential trigger without earlier first match");
  a_full_data: assert property ( // see RULE4
    trigger && mode == dbt_pkg::MODE_A_AND_DATA
    |-> busAddr == cmpFirst_reg && busData == cmpSecond_reg[DATA_W-1:0])
    else $error("full mode trigger without address and data match");
  a_full_notdata: assert property ( // see RULE5
    trigger && mode == dbt_pkg::MODE_A_NOT_DATA
    |-> busAddr == cmpFirst_reg && busData != cmpSecond_reg[DATA_W-1:0])
    else $error("not-data trigger with equal data");
  a_tag_break: assert property ( // see RULE6
    runActive_reg && busValid && brkEnable && tagMode && fullMode && busAddr == cmpFirst_reg
    |=> breakReq) else $error("tag breakpoint missed on first address match");
  a_store_capture: assert property ( // see RULE7
    runActive_reg && busValid && mode == dbt_pkg::MODE_STORE_B && busAddr == cmpSecond_reg
    && traceIf.inReady |-> capture ##1 validWords_reg != 4'h0)
    else $error("store event not captured");
  a_seq_store: assert property ( // see RULE8
    capture && mode == dbt_pkg::MODE_A_THEN_STORE |-> seqSeen_reg)
    else $error("capture before first match in sequential store");
  a_inside_range: assert property ( // see RULE9
    runActive_reg && busValid && mode == dbt_pkg::MODE_INSIDE
    |-> trigger == (busAddr >= cmpFirst_reg && busAddr <= cmpSecond_reg))
    else $error("inside range trigger wrong");
  a_outside_range: assert property ( // see RULE10
    runActive_reg && busValid && mode == dbt_pkg::MODE_OUTSIDE
    |-> trigger == (busAddr < cmpFirst_reg || busAddr > cmpSecond_reg))
    else $error("outside range trigger wrong");
  a_full_ends_run: assert property ( // see RULE11
    runActive_reg && !runStart && storeMode && !traceIf.inReady |=> !runActive_reg)
    else $error("run did not end on full buffer");
  a_start_clears: assert property ( // see RULE12
    runStart |=> !firstHit_reg && !secondHit_reg && validWords_reg == 4'h0)
    else $error("run start did not clear flags and count");
  a_count_holds: assert property ( // see RULE13
    !capture && !runStart |=> $stable(validWords_reg))
    else $error("valid count changed without capture");
  a_idle_quiet: assert property ( // see RULE14
    !runActive_reg |-> !trigger && !capture ##1 !breakReq)
    else $error("trigger or capture while disarmed");
endmodule // dbt_top
`default_nettype wire

// *** testbench/dbt_cpu_model.sv ***
// Processor bus model that issues single bus cycles on request.
`timescale 1ns/10ps
`default_nettype none
module dbt_cpu_model (
  input  wire logic        mclk,
  output var  logic        busValid,
  output var  logic [15:0] busAddr,
  output var  logic [7:0]  busData,
  output var  logic        busRead
);
  initial begin
    busValid = 1'h0;
    busAddr  = 16'hFFFF;
    busData  = 8'hFF;
    busRead  = 1'h0;
  end
  // Outside a cycle the lines show the inverse, so stale values never pass for live ones.
  task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic rd);
    @(posedge mclk);
    busValid <= 1'h1;
    busAddr  <= a;
    busData  <= d;
    busRead  <= rd;
    @(posedge mclk);
    busValid <= 1'h0;
    busAddr  <= ~a;
    busData  <= ~d;
    busRead  <= ~rd;
  endtask
endmodule // dbt_cpu_model
`default_nettype wire

// *** testbench/dbt_bench.sv ***
// Self-checking bench for the debug bus trigger block.
`timescale 1ns/10ps
`default_nettype none
module dbt_bench;
  localparam logic [15:0] A  = 16'h1000;
  localparam logic [15:0] AM = 16'h0FFF;
  localparam logic [15:0] AP = 16'h1001;
  localparam logic [15:0] B  = 16'h2055;
  localparam logic [15:0] BP = 16'h2056;
  localparam logic [7:0]  CT = dbt_pkg::CTRL_OFS;
  localparam logic [7:0]  ST = dbt_pkg::STATUS_OFS;
  localparam logic [7:0]  TR = dbt_pkg::TRACE_OFS;
  logic        mclk, rst, hsel, hwrite, hreadyout, hresp;
  logic        busValid, busRead, breakReq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] busAddr;
  logic [7:0]  busData;
  int          fails, total_checks, brkSeen;

  dbt_top dbt_top_i (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .busValid(busValid), .busAddr(busAddr),
    .busData(busData), .busRead(busRead), .breakReq(breakReq));
  dbt_cpu_model dbt_cpu_model_i (.mclk(mclk), .busValid(busValid), .busAddr(busAddr),
    .busData(busData), .busRead(busRead));

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  // Pulses are totalled here, so a scenario judges them after its status read.
  always @(posedge mclk) begin
    if (breakReq === 1'h1) brkSeen++;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // The master waits on hreadyout in each phase; only the bound here ends a stalled wait.
  task automatic hw;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 100);
    if (hreadyout !== 1'h1) begin
      fails++;
      complete_run;
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge mclk);
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= dbt_pkg::HTRANS_NONSEQ;
    hw;
    htrans <= 2'h0;
    hwdata <= d;
    hw;
    r = hrdata;
    chk(32'(hresp), 32'(dbt_pkg::HRESP_OKAY), "resp");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(a, 1'h1, d, r);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    ahb(a, 1'h0, 32'h00000000, r);
    chk(r & m, e, "read");
  endtask
  task automatic arm(input logic [3:0] md, input logic [7:0] lo);
    wr(CT, {20'h00000, md, lo & 8'hFD});
    wr(CT, {20'h00000, md, lo});
  endtask

  task automatic t_regs;
    rdm(CT, 32'hFFFFFFFF, 32'h00000000);
    rdm(ST, 32'hFFFFFFFF, 32'h00000000);
    wr(dbt_pkg::CMP_FIRST_OFS, {16'h0000, A});
    wr(dbt_pkg::CMP_SECOND_OFS, {16'h0000, B});
    rdm(dbt_pkg::CMP_FIRST_OFS, 32'hFFFFFFFF, {16'h0000, A});
    rdm(dbt_pkg::CMP_SECOND_OFS, 32'hFFFFFFFF, {16'h0000, B});
    rdm(8'h20, 32'hFFFFFFFF, 32'h00000000);
    rdm(TR, 32'hFFFFFFFF, 32'h00000000);
    $display("test regs done");
  endtask
  task automatic t_arm;
    int b;
    b = brkSeen;
    wr(CT, 32'h0000000A);
    dbt_cpu_model_i.cyc(A, 8'h00, 1'h1);
    rdm(ST, 32'hFFFFFFFF, 32'h00000000);
    chk(brkSeen - b, 0, "idle break");
    arm(4'h0, 8'h0B);
    rdm(ST, 32'hFFFFFFFF, 32'h00000020);
    wr(CT, 32'h00000009);
    rdm(ST, 32'hFFFFFFFF, 32'h00000000);
    $display("test arm done");
  endtask
  task automatic mcase(input logic [3:0] md, input logic [15:0] a1, a2, a3,
                       input logic [2:0] rv = 3'h7, input logic [7:0] d1 = 8'h00,
                       input logic [7:0] d2 = 8'h00, input logic [7:0] d3 = 8'h00);
    int b;
    arm(md, 8'h3B);
    b = brkSeen;
    dbt_cpu_model_i.cyc(a1, d1, rv[2]);
    dbt_cpu_model_i.cyc(a2, d2, rv[1]);
    rdm(ST, 32'h00000020, 32'h00000020);
    chk(brkSeen - b, 0, "early break");
    dbt_cpu_model_i.cyc(a3, d3, rv[0]);
    rdm(ST, 32'h00000020, 32'h00000000);
    chk(brkSeen - b, 1, "break");
  endtask
  task automatic t_modes;
    mcase(4'h0, B, AP, A);
    mcase(4'h1, AM, BP, B);
    mcase(4'h2, B, A, B);
    mcase(4'h3, A, A, A, 3'h5, 8'h54, 8'h55, 8'h55);
    mcase(4'h4, A, AP, A, 3'h7, 8'h55, 8'h00, 8'h00);
    mcase(4'h7, AM, BP, A);
    mcase(4'h7, AM, BP, B);
    mcase(4'h8, A, B, AM);
    mcase(4'h8, A, B, BP);
    $display("test modes done");
  endtask
  task automatic t_tag;
    int b;
    arm(4'h3, 8'h0F);
    b = brkSeen;
    dbt_cpu_model_i.cyc(A, 8'h00, 1'h1);
    rdm(ST, 32'h00000020, 32'h00000020);
    chk(brkSeen - b, 1, "tag break");
    wr(CT, 32'h00000001);
    $display("test tag done");
  endtask
  task automatic t_store(input logic [3:0] md);
    logic [7:0] base;
    base = (md == 4'h6) ? 8'h11 : 8'h10;
    arm(md, 8'h03);
    rdm(ST, 32'h000000EF, 32'h00000020);
    dbt_cpu_model_i.cyc(B, 8'h10, 1'h1);
    dbt_cpu_model_i.cyc(A, 8'h00, 1'h1);
    dbt_cpu_model_i.cyc(B, 8'h11, 1'h1);
    dbt_cpu_model_i.cyc(B, 8'h12, 1'h1);
    rdm(ST, 32'h00000020, 32'h00000020);
    for (int k = 0; k <= int'(md == 4'h6); k++) begin
      dbt_cpu_model_i.cyc(B, 8'h13 + 8'(k), 1'h1);
    end
    rdm(ST, 32'h000000EF, 32'h000000C4);
    for (int i = 0; i < 4; i++) begin
      rdm(TR, 32'hFFFFFFFF, {8'h00, B, base + 8'(i)});
    end
    rdm(TR, 32'hFFFFFFFF, 32'h00000000);
    rdm(ST, 32'h0000000F, 32'h00000004);
    $display("test store done");
  endtask
  task automatic t_begin;
    arm(4'h0, 8'h43);
    dbt_cpu_model_i.cyc(B, 8'h01, 1'h1);
    dbt_cpu_model_i.cyc(A, 8'h02, 1'h1);
    dbt_cpu_model_i.cyc(B, 8'h03, 1'h1);
    dbt_cpu_model_i.cyc(B, 8'h04, 1'h1);
    rdm(ST, 32'h00000020, 32'h00000020);
    dbt_cpu_model_i.cyc(B, 8'h05, 1'h1);
    rdm(ST, 32'h0000002F, 32'h00000004);
    rdm(TR, 32'hFFFFFFFF, {8'h00, A, 8'h02});
    $display("test begin done");
  endtask

  initial begin
    rst = 1'h1;
    hsel = 1'h1;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    repeat (8) @(posedge mclk);
    rst <= 1'h0;
    t_regs;
    t_arm;
    t_modes;
    t_tag;
    t_store(4'h5);
    t_store(4'h6);
    t_begin;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    complete_run;
  end
endmodule // dbt_bench
`default_nettype wire
